// ===== design/ssv_defs.svh
// Timing constants for the supply reset supervisor.
// Assumes a 100 MHz mclk; included by the package and the design module.
`ifndef SSV_DEFS_SVH
`define SSV_DEFS_SVH
`define SSV_CLK_HZ        100000000
`define SSV_DELAY0_MS     0
`define SSV_DELAY1_MS     55
`define SSV_DELAY2_MS     220
`define SSV_DELAY3_MS     450
`define SSV_DROP_US       20
`define SSV_DROP_CYC      ((`SSV_DROP_US * 100) > 0 ? (`SSV_DROP_US * 100) : 1)
`define SSV_MS_TO_CYC(ms) ((ms) * 100000)
`define SSV_GLITCH_CYC    16
`define SSV_CNT_W         26
`endif

// ===== design/ssv_pkg.sv
// Types shared by the supply reset supervisor.
// No surroundings assumed beyond the defs header.
`include "ssv_defs.svh"
package ssv_pkg;
  typedef enum logic [1:0] {
    SSV_DLY_0MS,
    SSV_DLY_55MS,
    SSV_DLY_220MS,
    SSV_DLY_450MS
  } ssv_delay_t;

  typedef struct packed {
    logic supplyLow;
    logic manualResetRequest_n;
  } ssv_inputs_t;

  typedef struct packed {
    logic resetOut;
    logic resetActive;
  } ssv_outputs_t;
endpackage

// ===== design/ssv_supervisor.sv
// Digital core of a supply-voltage reset supervisor.
// Assumes supplyLow comes from an analog comparator with hysteresis (asynchronous),
// and manual reset request arrives from a pin; both are synchronised here.
`timescale 1ns/10ps
`include "ssv_defs.svh"

// Function
// - Assert reset whenever the comparator reports supply below threshold.
// - Hold reset for the whole low-supply time, no self-timed release.
// - Release timer runs only while supply stays above threshold plus hysteresis.
// - Four build-time release delays: 0, 55, 220, 450 ms, both polarities.
// - Release delay counts stay inside the tolerance band of each option.
// - Reset asserts well within 20 us of supply drop.
// - Manual request input has no internal pull-up; the pin must be driven high to keep reset off.
// - Manual request causes reset only while driven low.
// - After manual request returns high, wait delay then follow supply.
// - Short glitches on manual request input are filtered out.
// - Output is push-pull, active-low or active-high per build parameter.
// - All logic including the timer starts in a defined state.
// - Reset held during manual request and full timeout after it.
module ssv_supervisor #(
  parameter ssv_pkg::ssv_delay_t DELAY_SEL   = ssv_pkg::SSV_DLY_220MS,
  parameter bit                  ACTIVE_HIGH = 1'b0,
  parameter int                  DELAY0_CYC  = `SSV_MS_TO_CYC(`SSV_DELAY0_MS),
  parameter int                  DELAY1_CYC  = `SSV_MS_TO_CYC(`SSV_DELAY1_MS),
  parameter int                  DELAY2_CYC  = `SSV_MS_TO_CYC(`SSV_DELAY2_MS),
  parameter int                  DELAY3_CYC  = `SSV_MS_TO_CYC(`SSV_DELAY3_MS),
  parameter int                  GLITCH_CYC  = `SSV_GLITCH_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire ssv_pkg::ssv_inputs_t  pins,
  output ssv_pkg::ssv_outputs_t      status
);
  import ssv_pkg::*;

  localparam int CW = `SSV_CNT_W;

  typedef enum logic [1:0] {
    SSV_ST_HOLD,
    SSV_ST_TIMING,
    SSV_ST_RELEASED
  } ssv_state_t;

  function automatic logic [CW-1:0] delayCycles(input ssv_delay_t sel);
    case (sel)
      SSV_DLY_0MS:   delayCycles = CW'(DELAY0_CYC);
      SSV_DLY_55MS:  delayCycles = CW'(DELAY1_CYC);
      SSV_DLY_220MS: delayCycles = CW'(DELAY2_CYC);
      default:       delayCycles = CW'(DELAY3_CYC);
    endcase
  endfunction

  localparam logic [CW-1:0] DELAY_CYC = delayCycles(DELAY_SEL);

  // Two-stage synchronisers; stage one is read only by stage two
  logic [1:0] lowSync;
  logic [1:0] mrSync;
  always_ff @(posedge mclk) begin
    if (reset) begin
      lowSync <= 2'h3;
      mrSync  <= 2'h3;
    end else begin
      lowSync <= {lowSync[0], pins.supplyLow};
      mrSync  <= {mrSync[0], pins.manualResetRequest_n};
    end
  end

  // Deglitch: a level must persist GLITCH_CYC cycles before it is accepted
  logic       mrFiltered_n;
  logic [7:0] glitchCnt;
  always_ff @(posedge mclk) begin
    if (reset) begin
      mrFiltered_n <= 1'b1;
      glitchCnt    <= 8'h00;
    end else if (mrSync[1] == mrFiltered_n) begin
      glitchCnt <= 8'h00;
    end else if (glitchCnt >= 8'(GLITCH_CYC - 1)) begin
      mrFiltered_n <= mrSync[1];
      glitchCnt    <= 8'h00;
    end else begin
      glitchCnt <= glitchCnt + 8'h01;
    end
  end

  // Low supply or a held manual request forces the hold state
  logic holdCause;
  assign holdCause = lowSync[1] | ~mrFiltered_n;

  ssv_state_t      state;
  ssv_state_t      next_state;
  logic [CW-1:0]   timer;

  always_comb begin
    next_state = state;
    case (state)
      SSV_ST_HOLD: begin
        if (!holdCause) begin
          next_state = (DELAY_CYC == '0) ? SSV_ST_RELEASED : SSV_ST_TIMING;
        end
      end
      SSV_ST_TIMING: begin
        if (holdCause) begin
          next_state = SSV_ST_HOLD;
        end else if (timer >= DELAY_CYC - CW'(1)) begin
          next_state = SSV_ST_RELEASED;
        end
      end
      default: begin
        if (holdCause) begin
          next_state = SSV_ST_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= SSV_ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Timer restarts on every hold so a bounce never shortens the delay
  always_ff @(posedge mclk) begin
    if (reset) begin
      timer <= '0;
    end else if (state == SSV_ST_TIMING && !holdCause) begin
      timer <= timer + CW'(1);
    end else begin
      timer <= '0;
    end
  end

  // Output from a flip-flop; push-pull so no pull-up is expected outside
  logic resetActive;
  always_ff @(posedge mclk) begin
    if (reset) begin
      resetActive <= 1'b1;
    end else begin
      resetActive <= (next_state != SSV_ST_RELEASED);
    end
  end

  // One driver for the whole struct; the pin is the flop or its inversion per ACTIVE_HIGH, so it cannot glitch
  assign status = '{resetOut: (ACTIVE_HIGH ? resetActive : ~resetActive),
                    resetActive: resetActive};

  // Checker helpers: run lengths of cause-free time and of each raw manual request level, saturating so they never wrap
  logic [CW-1:0] quietCnt;
  logic [7:0]    mrLowRun;
  logic [7:0]    mrHighRun;

  always_ff @(posedge mclk) begin
    if (reset) begin
      quietCnt <= '0;
    end else if (holdCause) begin
      quietCnt <= '0;
    end else if (quietCnt != '1) begin
      quietCnt <= quietCnt + CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mrLowRun <= 8'h00;
    end else if (mrSync[1]) begin
      mrLowRun <= 8'h00;
    end else if (mrLowRun != 8'hff) begin
      mrLowRun <= mrLowRun + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mrHighRun <= 8'h00;
    end else if (!mrSync[1]) begin
      mrHighRun <= 8'h00;
    end else if (mrHighRun != 8'hff) begin
      mrHighRun <= mrHighRun + 8'h01;
    end
  end

  a_low_forces_reset: assert property (@(posedge mclk) disable iff (reset)
    lowSync[1] |=> resetActive)
    else $error("reset not asserted while supply low");

  a_low_holds_reset: assert property (@(posedge mclk) disable iff (reset)
    (lowSync[1] && resetActive) |=> resetActive)
    else $error("reset released during low supply");

  a_drop_latency: assert property (@(posedge mclk) disable iff (reset)
    $rose(pins.supplyLow) |-> ##[1:4] resetActive)
    else $error("reset slow after supply drop");

  a_mr_holds_reset: assert property (@(posedge mclk) disable iff (reset)
    !mrFiltered_n |=> resetActive)
    else $error("manual request did not hold reset");

  a_glitch_rejected: assert property (@(posedge mclk) disable iff (reset)
    $fell(mrFiltered_n) |-> $past(mrSync[1], 1) == 1'b0 && glitchCnt == 8'h00)
    else $error("manual request accepted without filter");

  a_release_timed: assert property (@(posedge mclk) disable iff (reset)
    (state == SSV_ST_TIMING && timer < DELAY_CYC - CW'(1)) |=> resetActive)
    else $error("reset released before timeout");

  a_polarity_out: assert property (@(posedge mclk) disable iff (reset)
    status.resetOut == (ACTIVE_HIGH ? resetActive : !resetActive))
    else $error("output polarity wrong");

  a_timer_bound: assert property (@(posedge mclk) disable iff (reset)
    timer <= DELAY_CYC)
    else $error("timer exceeded delay");

  a_hold_restarts: assert property (@(posedge mclk) disable iff (reset)
    (state == SSV_ST_TIMING && holdCause) |=> (state == SSV_ST_HOLD && timer == '0))
    else $error("timer kept running under hold");

  a_init_state: assert property (@(posedge mclk)
    $fell(reset) |-> (state == SSV_ST_HOLD && resetActive))
    else $error("reset did not initialise logic");

  // Both synchronisers are exactly two stages once reset has flushed them
  a_sync_supply: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && !$past(reset, 2))
    |-> lowSync[1] == $past(pins.supplyLow, 2))
    else $error("supply synchroniser depth wrong");

  a_sync_manual: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && !$past(reset, 2))
    |-> mrSync[1] == $past(pins.manualResetRequest_n, 2))
    else $error("manual synchroniser depth wrong");

  // A new filter level needs a full run of the same raw level behind it
  a_filter_fall: assert property (@(posedge mclk) disable iff (reset)
    $fell(mrFiltered_n) |-> mrLowRun >= 8'(GLITCH_CYC))
    else $error("manual request accepted too soon");

  a_filter_rise: assert property (@(posedge mclk) disable iff (reset)
    $rose(mrFiltered_n) |-> mrHighRun >= 8'(GLITCH_CYC))
    else $error("manual request dropped too soon");

  a_quiet_before_fall: assert property (@(posedge mclk) disable iff (reset)
    $fell(resetActive) |-> quietCnt >= DELAY_CYC)
    else $error("release came before the full delay");

  a_released_quiet: assert property (@(posedge mclk) disable iff (reset)
    !resetActive |-> !$past(holdCause))
    else $error("released while a cause was present");

  a_hold_clears_timer: assert property (@(posedge mclk) disable iff (reset)
    (state == SSV_ST_HOLD) |-> (timer == '0))
    else $error("timer running during hold");

  a_timing_entry: assert property (@(posedge mclk) disable iff (reset)
    (state == SSV_ST_HOLD && !holdCause) |=> (state != SSV_ST_HOLD))
    else $error("timer not started after cause ended");

  a_timer_counts: assert property (@(posedge mclk) disable iff (reset)
    (state == SSV_ST_TIMING && !holdCause && timer < DELAY_CYC - CW'(1))
    |=> (timer == $past(timer) + CW'(1)))
    else $error("timer skipped a count");

  a_released_stays: assert property (@(posedge mclk) disable iff (reset)
    (state == SSV_ST_RELEASED && !holdCause) |=> (state == SSV_ST_RELEASED && !resetActive))
    else $error("output did not follow supply after release");

  a_manual_high_quiet: assert property (@(posedge mclk) disable iff (reset)
    (mrFiltered_n && !lowSync[1] && state == SSV_ST_RELEASED) |=> !resetActive)
    else $error("high manual level caused reset");
endmodule

// ===== dv/ssv_cpu_model.sv
// Processor reset input that sits on the far side of the supervisor output.
// Assumes the output is push-pull and sampled on mclk like a synchronous reset pin.
`timescale 1ns/10ps
module ssv_cpu_model #(
  parameter bit ACTIVE_HIGH = 1'b0
) (
  input  wire logic mclk,
  input  wire logic resetIn,
  output logic      held
);
  // Only senses the pin: no pull resistor is modelled, the output must drive both ways
  always_ff @(posedge mclk) begin
    held <= (resetIn === ACTIVE_HIGH);
  end
endmodule

// ===== dv/ssv_supervisor_test.sv
// Self-checking bench for the supply reset supervisor, 55 ms option shortened to DLY cycles.
// Assumes the design module and package are compiled first; partner model on the reset output.
`timescale 1ns/10ps
module ssv_supervisor_test;
  import ssv_pkg::*;
  localparam int DLY = 20;
  localparam int GL  = 16;
  logic         mclk      = 1'b0;
  logic         reset     = 1'b1;
  ssv_inputs_t  pins      = 2'h1;
  ssv_outputs_t status;
  ssv_outputs_t statusZero;
  logic         cpuHeld;
  int           numErrors = 0;
  int           cmpCount  = 0;

  always #5 mclk = ~mclk;

  ssv_supervisor #(.DELAY_SEL(SSV_DLY_55MS), .DELAY1_CYC(DLY), .GLITCH_CYC(GL)) ssv_supervisor_inst (
    .mclk(mclk), .reset(reset), .pins(pins), .status(status));
  ssv_cpu_model #(.ACTIVE_HIGH(1'b0)) ssv_cpu_model_inst (
    .mclk(mclk), .resetIn(status.resetOut), .held(cpuHeld));
  // Second build: zero delay, active-high pin, fed from the same inputs
  if (1) begin : zeroDly
    ssv_supervisor #(.DELAY_SEL(SSV_DLY_0MS), .ACTIVE_HIGH(1'b1), .GLITCH_CYC(GL)) ssv_supervisor_inst (
      .mclk(mclk), .reset(reset), .pins(pins), .status(statusZero));
  end

  task automatic wrapUp();
    $display("Compares %0d, mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Both builds: active-low pin is the inverse of the internal level, active-high pin equals it
  task automatic chkOut(input logic lvl);
    chk(status.resetActive, lvl, "reset level");
    chk(status.resetOut, ~lvl, "output pin level");
    chk(statusZero.resetActive, lvl, "zero-delay level");
    chk(statusZero.resetOut, lvl, "active-high pin level");
  endtask

  task automatic waitLevel(input logic lvl, input int bound);
    int c;
    c = 0;
    while (status.resetActive !== lvl && c < bound) begin
      cyc(1);
      c++;
    end
    chk(status.resetActive, lvl, "reset level not reached in time");
    if (status.resetActive !== lvl) wrapUp();
  endtask

  task automatic testInit();
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chkOut(1'b1);
    cyc(2);
    chk(cpuHeld, 1'b1, "processor not held after power-up");
    waitLevel(1'b0, DLY + 10);
    chkOut(1'b0);
    $display("init test done");
  endtask

  task automatic testSupply();
    @(posedge mclk);
    pins.supplyLow <= 1'b1;
    waitLevel(1'b1, 4);
    cyc(DLY * 3);
    chkOut(1'b1);
    @(posedge mclk);
    pins.supplyLow <= 1'b0;
    cyc(DLY);
    chk(status.resetActive, 1'b1, "supply release too early");
    chk(statusZero.resetActive, 1'b0, "zero-delay supply release late");
    waitLevel(1'b0, 8);
    $display("supply test done");
  endtask

  task automatic testGlitch();
    @(posedge mclk);
    pins.manualResetRequest_n <= 1'b0;
    repeat (GL / 2) @(posedge mclk);
    pins.manualResetRequest_n <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      cyc(1);
      chk(status.resetActive, 1'b0, "glitch caused reset");
    end
    $display("glitch test done");
  endtask

  task automatic testManual();
    @(posedge mclk);
    pins.manualResetRequest_n <= 1'b0;
    waitLevel(1'b1, GL + 6);
    cyc(DLY * 2);
    chkOut(1'b1);
    @(posedge mclk);
    pins.manualResetRequest_n <= 1'b1;
    cyc(DLY);
    chk(status.resetActive, 1'b1, "manual release too early");
    chk(statusZero.resetActive, 1'b0, "zero-delay manual release late");
    waitLevel(1'b0, GL + 8);
    $display("manual test done");
  endtask

  initial begin
    testInit();
    testSupply();
    testGlitch();
    testManual();
    wrapUp();
  end
endmodule
